// file: dv/ext_mem_model.sv
// External word-wide memory model answering the bus pins
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic        hclk,
  input  wire logic        chip_select_n,
  input  wire logic        output_gate_n,
  input  wire logic        address_latch_strobe,
  input  wire logic        write_strobe_high_n,
  input  wire logic        write_strobe_low_n,
  input  wire logic        upper_byte_sel_n,
  input  wire logic        lower_byte_sel_n,
  input  wire logic        byte_addr_bit,
  input  wire logic [15:0] ad_out,
  input  wire logic [3:0]  addr_hi_out,
  output logic      [15:0] ad_in,
  output logic      [19:0] lat_addr,
  output logic      [15:0] wr_data,
  output logic      [4:0]  wr_strb
);
  logic [15:0] last_val = 16'h0000;
  logic        drive;
  // ==========================================================
  // Read answer: word is the inverted latched address
  assign drive = !chip_select_n && !output_gate_n;
  // Released lines show the inverse of the last word, never a stale copy
  assign ad_in = drive ? ~lat_addr[15:0] : ~last_val;
  always @(posedge hclk) begin
    if (address_latch_strobe)
      lat_addr <= {addr_hi_out, ad_out};
    if (drive)
      last_val <= ~lat_addr[15:0];
    if (!chip_select_n && !(write_strobe_high_n && write_strobe_low_n)) begin
      wr_data <= ad_out;
      wr_strb <= {write_strobe_high_n, write_strobe_low_n, byte_addr_bit,
                  upper_byte_sel_n, lower_byte_sel_n};
    end
  end
endmodule // ext_mem_model

// file: dv/external_program_memory_bus_tb.sv
// Self-checking bench for the external program memory bus
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module external_program_memory_bus_tb;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  wr_strb;
  logic [31:0] hwdata, hrdata, r;
  logic        delay_insert_fuse, extended_mode, addr_width_20, sleep_mode;
  logic        exec_external, acc_req, acc_write, acc_ready, acc_done;
  logic [19:0] acc_addr, lat_addr;
  logic [15:0] acc_wdata, acc_rdata, ad_in, ad_out, ad_oe_n, wr_data;
  logic [3:0]  addr_hi_out;
  logic        addr_hi_oe_n, chip_select_n, output_gate_n, write_strobe_high_n;
  logic        write_strobe_low_n, upper_byte_sel_n, lower_byte_sel_n;
  logic        address_latch_strobe, byte_addr_bit, bus_owns_ad_pins, bus_owns_hi_pins;
  logic        port_d_pullup_en, port_e_pullup_en, port_j_pullup_en;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n;
  // ==========================================================
  // Design and memory
  assign hready = hreadyout;
  external_program_memory_bus uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .delay_insert_fuse,
    .extended_mode, .addr_width_20, .sleep_mode, .exec_external, .acc_req, .acc_write,
    .acc_addr, .acc_wdata, .acc_ready, .acc_done, .acc_rdata, .ad_in, .ad_out, .ad_oe_n,
    .addr_hi_out, .addr_hi_oe_n, .chip_select_n, .output_gate_n, .write_strobe_high_n,
    .write_strobe_low_n, .upper_byte_sel_n, .lower_byte_sel_n, .address_latch_strobe,
    .byte_addr_bit, .bus_owns_ad_pins, .bus_owns_hi_pins, .port_d_pullup_en,
    .port_e_pullup_en, .port_j_pullup_en);
  ext_mem_model mem (.hclk, .chip_select_n, .output_gate_n, .address_latch_strobe,
    .write_strobe_high_n, .write_strobe_low_n, .upper_byte_sel_n, .lower_byte_sel_n,
    .byte_addr_bit, .ad_out, .addr_hi_out,
    .ad_in, .lat_addr, .wr_data, .wr_strb);
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d);
    @(posedge hclk);
    acc_req <= 1'b1;
    acc_write <= w;
    acc_addr <= a;
    acc_wdata <= d;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (acc_ready !== 1'b1 && n < 50);
    @(posedge hclk);
    acc_req <= 1'b0;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
      if (n == 1)
        check({chip_select_n, address_latch_strobe, bus_owns_ad_pins, ad_oe_n[0], addr_hi_oe_n},
              5'b01100);
    end while (acc_done !== 1'b1 && n < 50);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    ahb(1'b0, `EBUS_CTRL_OFS, 32'h0000_0000);
    check(r, 32'h0000_0030);
    ahb(1'b0, 8'h0c, 32'h0000_0000);
    check(r, 32'h0000_0000);
    ahb(1'b0, `EBUS_STAT_OFS, 32'h0000_0000);
    check(r, 32'h0000_001a);
    @(negedge hclk);
    check({port_d_pullup_en, port_e_pullup_en, port_j_pullup_en}, 3'b000);
    check({chip_select_n, output_gate_n, write_strobe_high_n, write_strobe_low_n,
           upper_byte_sel_n, lower_byte_sel_n, address_latch_strobe, byte_addr_bit},
          8'hfc);
    check({hreadyout, hresp, ad_oe_n, bus_owns_ad_pins}, 19'h5_ffff);
  endtask
  task automatic t_pullup;
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, `EBUS_PAD_OFS, i << 5);
      ahb(1'b0, `EBUS_PAD_OFS, 32'h0000_0000);
      check(r, i << 5);
      check({port_d_pullup_en, port_e_pullup_en, port_j_pullup_en}, i);
    end
  endtask
  task automatic t_internal;
    @(posedge hclk);
    extended_mode <= 1'b0;
    ahb(1'b1, `EBUS_CTRL_OFS, 32'h0000_0001);
    ahb(1'b0, `EBUS_CTRL_OFS, 32'h0000_0000);
    check(r, 32'h0000_0030);
    check({acc_ready, bus_owns_ad_pins, bus_owns_hi_pins}, 3'b000);
    extended_mode <= 1'b1;
  endtask
  task automatic t_wait;
    for (int f = 0; f < 2; f++) begin
      @(posedge hclk);
      delay_insert_fuse <= f[0];
      for (int w = 0; w < 4; w++) begin
        ahb(1'b1, `EBUS_CTRL_OFS, w << 4);
        acc(1'b0, 20'(20'ha_1230 + w), 16'h0000);
        check(n, 5 + f * w);
        check(lat_addr, 20'(20'ha_1230 + w));
        check(acc_rdata, 16'(~(16'h1230 + w)));
        acc(1'b1, 20'h5_0f00, 16'hbeef);
        check(n, 3 + f * w);
      end
    end
    @(posedge hclk);
    delay_insert_fuse <= 1'b0;
  endtask
  task automatic t_wmode;
    logic [4:0] e;
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < 2; b++) begin
        ahb(1'b1, `EBUS_CTRL_OFS, m);
        acc(1'b1, 20'h0_4440 + b, 16'h9a50 + m);
        // Strobe word: high write, low write, byte bit, upper select, lower select
        e = (m == 0) ? (b ? 5'b01011 : 5'b10011) :
            (m == 2) ? (b ? 5'b01101 : 5'b01010) : 5'b00000;
        check(wr_strb, e);
        check(wr_data, 16'h9a50 + m);
      end
    end
  endtask
  task automatic t_release;
    @(posedge hclk);
    exec_external <= 1'b1;
    ahb(1'b1, `EBUS_CTRL_OFS, 32'h0000_0080);
    repeat (2) @(negedge hclk);
    check(bus_owns_ad_pins, 1'b1);
    @(posedge hclk);
    exec_external <= 1'b0;
    repeat (2) @(negedge hclk);
    check({bus_owns_ad_pins, port_d_pullup_en, port_j_pullup_en}, 3'b011);
    acc(1'b0, 20'h0_0077, 16'h0000);
    check(acc_rdata, 16'hff88);
    repeat (3) @(negedge hclk);
    check(bus_owns_ad_pins, 1'b0);
    ahb(1'b1, `EBUS_CTRL_OFS, 32'h0000_0000);
    repeat (2) @(negedge hclk);
    check(bus_owns_ad_pins, 1'b1);
  endtask
  task automatic t_width_sleep;
    @(posedge hclk);
    addr_width_20 <= 1'b0;
    @(negedge hclk);
    check({bus_owns_hi_pins, addr_hi_oe_n, bus_owns_ad_pins}, 3'b011);
    @(posedge hclk);
    addr_width_20 <= 1'b1;
    @(negedge hclk);
    check(bus_owns_hi_pins, 1'b1);
    // Sleep rises on the same edge that accepts a read, so the select must stay high
    @(posedge hclk);
    acc_req <= 1'b1;
    @(posedge hclk);
    acc_req <= 1'b0;
    sleep_mode <= 1'b1;
    @(negedge hclk);
    check(chip_select_n, 1'b1);
    repeat (6) @(negedge hclk);
    check({chip_select_n, acc_ready}, 2'b10);
    @(posedge hclk);
    sleep_mode <= 1'b0;
    ahb(1'b1, `EBUS_PAD_OFS, 32'h0000_00e0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check({port_d_pullup_en, port_e_pullup_en, port_j_pullup_en}, 3'b000);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {hresetn, hwrite, acc_req, acc_write, sleep_mode, exec_external} = 6'h00;
    {hsel, delay_insert_fuse, extended_mode, addr_width_20} = 4'hf;
    {haddr, htrans, hsize, hwdata} = {8'h00, 2'h0, 3'h2, 32'h0000_0000};
    {acc_addr, acc_wdata} = 36'h0_0000_0000;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_internal;
    t_pullup;
    t_wait;
    t_wmode;
    t_release;
    t_width_sleep;
    results;
  end
endmodule // external_program_memory_bus_tb

// file: hw/ext_bus_map.svh
// Offsets, field positions, reset values and timing figures of the external memory bus
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
// ==========================================================
// Register offsets (byte addresses)
`define EBUS_CTRL_OFS      8'h00
`define EBUS_PAD_OFS       8'h04
`define EBUS_STAT_OFS      8'h08
// ==========================================================
// Control register fields
`define EBUS_REL_BIT       7
`define EBUS_WAIT_HI       5
`define EBUS_WAIT_LO       4
`define EBUS_WM_HI         1
`define EBUS_WM_LO         0
`define EBUS_CTRL_RST      8'h30
`define EBUS_CTRL_WMASK    8'hb3
// ==========================================================
// Pad register fields
`define EBUS_PUD_BIT       7
`define EBUS_PUE_BIT       6
`define EBUS_PUJ_BIT       5
`define EBUS_PAD_RST       8'h00
`define EBUS_PAD_WMASK     8'he0
// ==========================================================
// Write mode codes, chosen freely; the fourth code acts as word write
`define EBUS_WM_BYTE_WR    2'h0
`define EBUS_WM_WORD_WR    2'h1
`define EBUS_WM_BYTE_SEL   2'h2
// ==========================================================
// Timing
`define EBUS_CLK_NS        100
`define EBUS_TCY_NS        100
`define EBUS_SYNC_CYC      2'h2
`endif

// file: hw/ext_bus_pkg.sv
// Types shared by the external memory bus design
package ext_bus_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ADDR = 6'b00_0010,
    ST_STRB = 6'b00_0100,
    ST_WAIT = 6'b00_1000,
    ST_SYNC = 6'b01_0000,
    ST_DONE = 6'b10_0000
  } bus_state_t;
endpackage

// file: hw/ext_bus_wait_counter.sv
// Down counter that times the inserted wait states
`timescale 1ns/1ps
module ext_bus_wait_counter (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       load,
  input  wire logic [3:0] load_val,
  output logic            expired
);
  logic [3:0] count_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= 4'h0;
    end else if (load) begin
      count_reg <= load_val;
    end else if (count_reg != 4'h0) begin
      count_reg <= count_reg - 4'h1;
    end
  end

  assign expired = (count_reg <= 4'h1);
endmodule // ext_bus_wait_counter

// file: hw/external_program_memory_bus.sv
// External program memory bus: AHB-Lite registers, access sequencer and pin ownership
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module external_program_memory_bus
  import ext_bus_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        delay_insert_fuse,
  input  wire logic        extended_mode,
  input  wire logic        addr_width_20,
  input  wire logic        sleep_mode,
  input  wire logic        exec_external,
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic [19:0] acc_addr,
  input  wire logic [15:0] acc_wdata,
  output logic             acc_ready,
  output logic             acc_done,
  output logic [15:0]      acc_rdata,
  input  wire logic [15:0] ad_in,
  output logic [15:0]      ad_out,
  output logic [15:0]      ad_oe_n,
  output logic [3:0]       addr_hi_out,
  output logic             addr_hi_oe_n,
  output logic             chip_select_n,
  output logic             output_gate_n,
  output logic             write_strobe_high_n,
  output logic             write_strobe_low_n,
  output logic             upper_byte_sel_n,
  output logic             lower_byte_sel_n,
  output logic             address_latch_strobe,
  output logic             byte_addr_bit,
  output logic             bus_owns_ad_pins,
  output logic             bus_owns_hi_pins,
  output logic             port_d_pullup_en,
  output logic             port_e_pullup_en,
  output logic             port_j_pullup_en
);
  localparam int WAIT_UNIT = (`EBUS_TCY_NS + `EBUS_CLK_NS - 1) / `EBUS_CLK_NS;

  // ==========================================================
  // AHB-Lite register slave
  logic [7:0]  ext_bus_control_reg;
  logic [7:0]  pad_setup_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        release_eff_reg;
  logic        addr_phase;
  bus_state_t  state_reg;
  bus_state_t  state_next;
  logic [7:0]  status_val;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_phase = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr;
    end
  end

  // Control writes only take effect in extended mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_bus_control_reg <= `EBUS_CTRL_RST;
    end else if (wr_pend_reg && wr_addr_reg == `EBUS_CTRL_OFS && extended_mode) begin
      ext_bus_control_reg <= hwdata[7:0] & `EBUS_CTRL_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_setup_reg <= `EBUS_PAD_RST;
    end else if (wr_pend_reg && wr_addr_reg == `EBUS_PAD_OFS) begin
      pad_setup_reg <= hwdata[7:0] & `EBUS_PAD_WMASK;
    end
  end

  assign status_val = {3'h0, delay_insert_fuse, extended_mode, release_eff_reg,
                       bus_owns_ad_pins, (state_reg != ST_IDLE)};

  // Read data registered in the address phase so the slave never stalls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      case (haddr)
        `EBUS_CTRL_OFS: hrdata <= {24'h00_0000, ext_bus_control_reg};
        `EBUS_PAD_OFS:  hrdata <= {24'h00_0000, pad_setup_reg};
        `EBUS_STAT_OFS: hrdata <= {24'h00_0000, status_val};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Pull-ups: plain enables, never gated by the release state
  assign port_d_pullup_en = pad_setup_reg[`EBUS_PUD_BIT];
  assign port_e_pullup_en = pad_setup_reg[`EBUS_PUE_BIT];
  assign port_j_pullup_en = pad_setup_reg[`EBUS_PUJ_BIT];

  // ==========================================================
  // Release handover is held back while code runs from external memory
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      release_eff_reg <= 1'b0;
    end else if (!exec_external) begin
      release_eff_reg <= ext_bus_control_reg[`EBUS_REL_BIT];
    end
  end

  // ==========================================================
  // Pad input synchroniser
  logic [15:0] ad_meta_reg;
  logic [15:0] ad_sync_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ad_meta_reg <= 16'h0000;
      ad_sync_reg <= 16'h0000;
    end else begin
      ad_meta_reg <= ad_in;
      ad_sync_reg <= ad_meta_reg;
    end
  end

  // ==========================================================
  // Access sequencer
  logic        take;
  logic        busy;
  logic [1:0]  wait_sel;
  logic [3:0]  wait_load;
  logic        wait_expired;
  logic [1:0]  sync_cnt_reg;
  logic        op_write_reg;
  logic [19:0] op_addr_reg;
  logic [15:0] op_wdata_reg;
  logic [1:0]  wm;

  assign busy      = (state_reg != ST_IDLE);
  assign acc_ready = extended_mode && !sleep_mode && (state_reg == ST_IDLE);
  assign take      = acc_req && acc_ready;
  assign wm        = ext_bus_control_reg[`EBUS_WM_HI:`EBUS_WM_LO];
  assign wait_sel  = delay_insert_fuse ?
                     ext_bus_control_reg[`EBUS_WAIT_HI:`EBUS_WAIT_LO] : 2'h0;
  assign wait_load = 4'(int'(wait_sel) * WAIT_UNIT);

  ext_bus_wait_counter u_wait (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (state_reg == ST_STRB),
    .load_val (wait_load),
    .expired  (wait_expired)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_write_reg <= 1'b0;
      op_addr_reg  <= 20'h0_0000;
      op_wdata_reg <= 16'h0000;
    end else if (take) begin
      op_write_reg <= acc_write;
      op_addr_reg  <= acc_addr;
      op_wdata_reg <= acc_wdata;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (take) state_next = ST_ADDR;
      ST_ADDR: state_next = ST_STRB;
      ST_STRB: begin
        if (wait_sel != 2'h0) state_next = ST_WAIT;
        else if (op_write_reg) state_next = ST_DONE;
        else state_next = ST_SYNC;
      end
      ST_WAIT: begin
        if (wait_expired) state_next = op_write_reg ? ST_DONE : ST_SYNC;
      end
      ST_SYNC: if (sync_cnt_reg == 2'h1) state_next = ST_DONE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reads hold the gate two extra cycles to cover the pad synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_cnt_reg <= 2'h0;
    end else if (state_reg != ST_SYNC) begin
      sync_cnt_reg <= `EBUS_SYNC_CYC;
    end else begin
      sync_cnt_reg <= sync_cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_rdata <= 16'h0000;
      acc_done  <= 1'b0;
    end else begin
      acc_done <= (state_reg == ST_SYNC && sync_cnt_reg == 2'h1) ||
                  (state_next == ST_DONE && op_write_reg && state_reg != ST_DONE);
      if (state_reg == ST_SYNC && sync_cnt_reg == 2'h1) begin
        acc_rdata <= ad_sync_reg;
      end
    end
  end

  // ==========================================================
  // Pin ownership and pin values
  logic strobing;
  logic drive_data;
  logic hi_byte;

  assign strobing   = (state_reg == ST_STRB) || (state_reg == ST_WAIT) ||
                      (state_reg == ST_SYNC);
  assign drive_data = (state_reg == ST_ADDR) || (op_write_reg && strobing);
  assign hi_byte    = op_addr_reg[0];

  // Extended mode only: bus takes pins for any access, otherwise release decides; peripherals follow
  assign bus_owns_ad_pins = extended_mode && (busy || !release_eff_reg);
  assign bus_owns_hi_pins = bus_owns_ad_pins && addr_width_20;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ad_out       <= 16'h0000;
      addr_hi_out  <= 4'h0;
    end else begin
      ad_out      <= (state_next == ST_ADDR) ? acc_addr[15:0] : op_wdata_reg;
      addr_hi_out <= (state_next == ST_ADDR) ? acc_addr[19:16] : addr_hi_out;
    end
  end

  // Idle bus: data released, active-low controls high, latch and byte bit low
  assign ad_oe_n       = (bus_owns_ad_pins && drive_data) ? 16'h0000 : 16'hffff;
  assign addr_hi_oe_n  = !(bus_owns_hi_pins && busy);
  assign chip_select_n = sleep_mode || !busy || state_reg == ST_DONE;
  assign address_latch_strobe = (state_reg == ST_ADDR);
  assign output_gate_n = !(strobing && !op_write_reg);

  always_comb begin
    write_strobe_high_n = 1'b1;
    write_strobe_low_n  = 1'b1;
    upper_byte_sel_n    = 1'b1;
    lower_byte_sel_n    = 1'b1;
    byte_addr_bit       = 1'b0;
    if (strobing) begin
      if (!op_write_reg) begin
        upper_byte_sel_n = 1'b0;
        lower_byte_sel_n = 1'b0;
      end else begin
        case (wm)
          `EBUS_WM_BYTE_WR: begin
            write_strobe_high_n = !hi_byte;
            write_strobe_low_n  = hi_byte;
          end
          `EBUS_WM_BYTE_SEL: begin
            write_strobe_high_n = 1'b0;
            upper_byte_sel_n    = !hi_byte;
            lower_byte_sel_n    = hi_byte;
            byte_addr_bit       = hi_byte;
          end
          default: begin
            write_strobe_high_n = 1'b0;
            write_strobe_low_n  = 1'b0;
            upper_byte_sel_n    = 1'b0;
            lower_byte_sel_n    = 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_strobe_start;
    state_reg == ST_ADDR ##1 state_reg == ST_STRB;
  endsequence

  a_no_wait_off: assert property (
    (state_reg == ST_STRB && !delay_insert_fuse) |=> state_reg != ST_WAIT)
    else $error("wait state inserted with fuse off");
  a_wait_three: assert property (
    (state_reg == ST_STRB && wait_sel == 2'h3 && op_write_reg) |=>
      state_reg == ST_WAIT [*3] ##1 state_reg == ST_DONE)
    else $error("three wait cycles not inserted");
  a_wait_after: assert property (
    s_strobe_start ##0 (wait_sel == 2'h1) |=> state_reg == ST_WAIT ##1 state_reg != ST_WAIT)
    else $error("single wait cycle misplaced");
  a_pullup_map: assert property (
    port_j_pullup_en == pad_setup_reg[5] && port_d_pullup_en == pad_setup_reg[7])
    else $error("pull-up enable mapped wrongly");
  a_ctrl_blocked: assert property (
    !extended_mode |-> (!bus_owns_ad_pins && !acc_ready) ##1 $stable(ext_bus_control_reg))
    else $error("control changed or bus active in internal mode");
  a_access_owns: assert property (
    take |=> bus_owns_ad_pins [*3])
    else $error("pins not owned during access");
  a_defer_release: assert property (
    (exec_external && !busy) |=> release_eff_reg == $past(release_eff_reg))
    else $error("release applied from external code");
  a_idle_pins: assert property (
    (bus_owns_ad_pins && !busy) |-> ad_oe_n == 16'hffff && output_gate_n &&
      write_strobe_low_n && !address_latch_strobe && !byte_addr_bit)
    else $error("idle bus pins wrong");
  a_latch_gate: assert property (
    (address_latch_strobe && !op_write_reg) |=> !output_gate_n && !ad_oe_n[0] == 1'b0)
    else $error("gate does not follow latch");
  a_cs_sleep: assert property (
    (sleep_mode || address_latch_strobe) |-> (chip_select_n == sleep_mode))
    else $error("chip select wrong");
endmodule // external_program_memory_bus
